// [hw/aux_tx_pkg.sv]
// Shared types and constants for the auxiliary transmit insertion path.
// Assumes a single core clock domain; no software-visible registers.
package aux_tx_pkg;

    // =========================================================
    // Frame geometry defaults
    // =========================================================
    localparam int WORDS_PER_BF_DEF = 4;     // 32-bit words per basic frame
    localparam int LATENCY_DEF = 0;          // Extra write latency cycles
    localparam int HFN_MAX_DEF = 149;        // Last hyperframe number
    localparam int BF_MAX = 255;             // Last basic frame index
    localparam int LANES = 4;                // Byte lanes per word

    // =========================================================
    // Protected control character and reset values
    // =========================================================
    localparam logic [7:0] SYNC_CHAR = 8'hBC;
    localparam logic [7:0] HFN_RST = 8'h00;
    localparam logic [7:0] BF_RST = 8'h00;
    localparam logic [6:0] SEQ_RST = 7'h00;

    // Frame position shown to user logic
    typedef struct packed {
        logic [7:0] hfn;    // Hyperframe number
        logic [7:0] bf;     // Basic frame within hyperframe
        logic [6:0] seq;    // Word within basic frame
        logic [3:0] ctrl;   // Control byte lanes of this word
    } pos_s;

    // Word leaving the block toward the line side
    typedef struct packed {
        logic [31:0] data;
        pos_s pos;
    } frame_word_s;

    // Frame synchronisation states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ALIGN,
        ST_RUN
    } sync_state_e;

endpackage : aux_tx_pkg

// [hw/aux_tx_write_latency_insert.sv]
// Auxiliary transmit insertion: publishes frame position, takes masked
// words back after 1+LATENCY cycles, flags overwrites of the sync char (hyperframe 0, basic frame 0).
// Assumes user logic on core_clk and a line-side sink with ready.
//
// Overview of operation
// - Master resets hyperframe and basic frame counters on resync pulse.
// - Write latency is one cycle at zero, else one plus N cycles.
// - Latency counts from word index shown to data driven for it.
// - Same latency serves all direct interfaces; others signal ready.
// - Mask over protected control byte raises error next cycle.
// - Each control indicator bit marks a control byte lane of shown word.
// - Sync pulses and counters come from the frame sync state machine.
// - At zero latency, data seen with index 1 fills index 0 slot.
// - A set mask bit makes aux data win over every other source.
// - Words are 32 bits; bits 31 to 24 go first, 7 to 0 last.
// - Basic frame index is an 8-bit value from 0 to 255.
`timescale 1ns/1ps

module aux_tx_write_latency_insert #(
    parameter int WORDS_PER_BF = aux_tx_pkg::WORDS_PER_BF_DEF,
    parameter int LATENCY = aux_tx_pkg::LATENCY_DEF,
    parameter int HFN_MAX = aux_tx_pkg::HFN_MAX_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Mode and link status
    input wire logic radio_controller_master,
    input wire logic link_up,
    input wire logic rx_hf_start,
    // Position toward user logic
    output aux_tx_pkg::pos_s aux_tx_pos,
    output logic aux_tx_bf_pulse,
    output logic aux_tx_hf_pulse,
    output logic aux_tx_running,
    // Data from user logic
    input wire logic aux_tx_sync_rfp,
    input wire logic [31:0] aux_tx_data,
    input wire logic [31:0] aux_tx_mask,
    input wire logic [31:0] core_word,
    output logic aux_tx_err,
    output logic aux_tx_stall,
    // Line side
    output aux_tx_pkg::frame_word_s tx_word,
    output logic tx_valid,
    input wire logic tx_ready
);
    import aux_tx_pkg::*;

    localparam int CW_BYTES = WORDS_PER_BF / LANES;
    localparam logic [6:0] SEQ_LAST = 7'(WORDS_PER_BF - 1);
    localparam logic [7:0] HFN_LAST = 8'(HFN_MAX);
    localparam logic [7:0] BF_LAST = 8'(BF_MAX);

    // =========================================================
    // Elaboration checks
    // =========================================================
    if (WORDS_PER_BF < 4 || WORDS_PER_BF > 80 || WORDS_PER_BF % 4 != 0)
        $error("WORDS_PER_BF must be a multiple of 4 from 4 to 80");
    if (LATENCY < 0 || LATENCY > 64)
        $error("LATENCY must be 0 to 64");
    if (HFN_MAX < 1 || HFN_MAX > 255)
        $error("HFN_MAX must be 1 to 255");

    // Control lanes of a word; byte 31:24 is the earliest in the frame
    function automatic logic [3:0] ctrl_lanes(input logic [6:0] seq);
        logic [3:0] lanes;
        int byte_idx;
        lanes = 4'h0;
        for (int l = 0; l < LANES; l++) begin
            byte_idx = int'(seq) * LANES + l;
            lanes[LANES-1-l] = (byte_idx < CW_BYTES);
        end
        return lanes;
    endfunction : ctrl_lanes

    // =========================================================
    // Frame sync state machine and position counters
    // =========================================================
    sync_state_e state_reg, state_next;
    pos_s pos_reg, pos_next;
    logic bf_pulse_reg, bf_pulse_next;
    logic hf_pulse_reg, hf_pulse_next;
    logic stall;
    logic run_reg;
    logic advance;

    assign advance = (state_reg == ST_RUN) && !stall;

    // Next state and position
    always_comb begin
        state_next = state_reg;
        pos_next = pos_reg;
        bf_pulse_next = 1'b0;
        hf_pulse_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                pos_next = '{HFN_RST, BF_RST, SEQ_RST, ctrl_lanes(SEQ_RST)};
                if (link_up) begin
                    state_next = radio_controller_master ? ST_RUN : ST_ALIGN;
                    bf_pulse_next = radio_controller_master;
                    hf_pulse_next = radio_controller_master;
                end
            end
            ST_ALIGN: begin
                // Slave waits for received hyperframe start
                if (!link_up) begin
                    state_next = ST_IDLE;
                end else if (rx_hf_start) begin
                    state_next = ST_RUN;
                    bf_pulse_next = 1'b1;
                    hf_pulse_next = 1'b1;
                end
            end
            ST_RUN: begin
                if (!link_up) begin
                    state_next = ST_IDLE;
                end else if (radio_controller_master && aux_tx_sync_rfp) begin
                    pos_next = '{HFN_RST, BF_RST, SEQ_RST,
                                 ctrl_lanes(SEQ_RST)};
                    bf_pulse_next = 1'b1;
                    hf_pulse_next = 1'b1;
                end else if (advance) begin
                    // Counters step once per word
                    if (pos_reg.seq == SEQ_LAST) begin
                        pos_next.seq = SEQ_RST;
                        bf_pulse_next = 1'b1;
                        if (pos_reg.bf == BF_LAST) begin
                            pos_next.bf = BF_RST;
                            hf_pulse_next = 1'b1;
                            pos_next.hfn = (pos_reg.hfn == HFN_LAST) ?
                                HFN_RST : pos_reg.hfn + 8'h01;
                        end else begin
                            pos_next.bf = pos_reg.bf + 8'h01;
                        end
                    end else begin
                        pos_next.seq = pos_reg.seq + 7'h01;
                    end
                    pos_next.ctrl = ctrl_lanes(pos_next.seq);
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Register state and position
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            run_reg <= 1'b0;
            pos_reg <= '0;
            bf_pulse_reg <= 1'b0;
            hf_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            run_reg <= (state_next == ST_RUN);
            pos_reg <= pos_next;
            bf_pulse_reg <= bf_pulse_next;
            hf_pulse_reg <= hf_pulse_next;
        end
    end

    // =========================================================
    // Position delay line of 1+LATENCY stages
    // =========================================================
    pos_s dly_reg [0:LATENCY], dly_next [0:LATENCY];
    logic [LATENCY:0] dly_v_reg, dly_v_next;

    // Shift the shown position toward the capture point
    always_comb begin
        dly_next = dly_reg;
        dly_v_next = dly_v_reg;
        if (state_reg != ST_RUN) begin
            dly_v_next = '0;
        end else if (!stall) begin
            dly_next[0] = pos_reg;
            dly_v_next[0] = 1'b1;
            for (int i = 1; i <= LATENCY; i++) begin
                dly_next[i] = dly_reg[i-1];
                dly_v_next[i] = dly_v_reg[i-1];
            end
        end
    end

    // Register delay line
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i <= LATENCY; i++) begin
                dly_reg[i] <= '0;
            end
            dly_v_reg <= '0;
        end else begin
            dly_reg <= dly_next;
            dly_v_reg <= dly_v_next;
        end
    end

    // =========================================================
    // Insertion and protected-byte check
    // =========================================================
    pos_s cap_pos;
    logic capture;
    logic [31:0] prot_mask;
    logic [31:0] base_word;
    frame_word_s ins_word;
    logic err_reg, err_next;

    // Data now on the port targets the oldest delayed position
    assign cap_pos = dly_reg[LATENCY];
    assign capture = dly_v_reg[LATENCY] && !stall;

    // Sync character lanes only when hyperframe and basic frame are zero
    always_comb begin
        prot_mask = 32'h0000_0000;
        base_word = core_word;
        for (int l = 0; l < LANES; l++) begin
            if (cap_pos.ctrl[l] && cap_pos.hfn == HFN_RST &&
                cap_pos.bf == BF_RST) begin
                prot_mask[l*8 +: 8] = 8'hFF;
                base_word[l*8 +: 8] = SYNC_CHAR;
            end
        end
        // Mask bit selects aux data over every other source
        ins_word.data = (aux_tx_mask & aux_tx_data) |
                        (~aux_tx_mask & base_word);
        ins_word.pos = cap_pos;
        err_next = capture && |(aux_tx_mask & prot_mask);
    end

    // Register error pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    // =========================================================
    // Two-entry output buffer
    // =========================================================
    frame_word_s head_reg, head_next, skid_reg, skid_next;
    logic head_v_reg, head_v_next, skid_v_reg, skid_v_next;

    // Stall the framer while a word waits in the skid slot
    assign stall = skid_v_reg;

    // Head is the visible slot; skid holds one word during a stall
    always_comb begin
        head_next = head_reg;
        skid_next = skid_reg;
        head_v_next = head_v_reg;
        skid_v_next = skid_v_reg;
        if (head_v_reg && tx_ready) begin
            head_v_next = skid_v_reg;
            head_next = skid_reg;
            skid_v_next = 1'b0;
        end
        if (capture) begin
            if (!head_v_next) begin
                head_next = ins_word;
                head_v_next = 1'b1;
            end else begin
                skid_next = ins_word;
                skid_v_next = 1'b1;
            end
        end
    end

    // Register buffer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            head_reg <= '0;
            skid_reg <= '0;
            head_v_reg <= 1'b0;
            skid_v_reg <= 1'b0;
        end else begin
            head_reg <= head_next;
            skid_reg <= skid_next;
            head_v_reg <= head_v_next;
            skid_v_reg <= skid_v_next;
        end
    end

    // =========================================================
    // Outputs, all from flip-flops
    // =========================================================
    assign aux_tx_pos = pos_reg;
    assign aux_tx_bf_pulse = bf_pulse_reg;
    assign aux_tx_hf_pulse = hf_pulse_reg;
    assign aux_tx_running = run_reg;
    assign aux_tx_err = err_reg;
    assign aux_tx_stall = skid_v_reg;
    assign tx_word = head_reg;
    assign tx_valid = head_v_reg;

endmodule : aux_tx_write_latency_insert

// [verif/aux_tx_write_latency_insert_properties.sv]
// Checker for the auxiliary transmit insertion block.
// Assumes one core_clk domain and sys_rst synchronous, active high.
`timescale 1ns/1ps
module aux_tx_write_latency_insert_properties #(
    parameter int WORDS_PER_BF = 4,
    parameter int LATENCY = 0,
    parameter int HFN_MAX = 149
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Mode and link
    input wire logic radio_controller_master,
    input wire logic link_up,
    input wire logic rx_hf_start,
    // Position
    input aux_tx_pkg::pos_s aux_tx_pos,
    input wire logic aux_tx_bf_pulse,
    input wire logic aux_tx_hf_pulse,
    input wire logic aux_tx_running,
    // User words
    input wire logic aux_tx_sync_rfp,
    input wire logic [31:0] aux_tx_data,
    input wire logic [31:0] aux_tx_mask,
    input wire logic [31:0] core_word,
    input wire logic aux_tx_err,
    input wire logic aux_tx_stall,
    // Line side
    input aux_tx_pkg::frame_word_s tx_word,
    input wire logic tx_valid,
    input wire logic tx_ready
);
    import aux_tx_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // =====================================================
    // Position and pulses
    // =====================================================
    a_run_start: assert property ($rose(aux_tx_running) |->
        {aux_tx_pos.hfn, aux_tx_pos.bf, aux_tx_pos.seq} == 23'h0
        && aux_tx_bf_pulse && aux_tx_hf_pulse) else $error("bad start");
    a_bf_pulse: assert property (aux_tx_bf_pulse |->
        aux_tx_pos.seq == 7'h00) else $error("bf pulse off word 0");
    a_hf_pulse: assert property (aux_tx_hf_pulse |->
        aux_tx_bf_pulse && aux_tx_pos.bf == 8'h00) else $error("hf pulse");
    a_seq_step: assert property (aux_tx_running && link_up
        && !aux_tx_stall && !aux_tx_sync_rfp
        && aux_tx_pos.seq < 7'(WORDS_PER_BF - 1) |=>
        aux_tx_pos.seq == $past(aux_tx_pos.seq) + 7'h01)
        else $error("word index did not step");
    a_resync_zero: assert property (radio_controller_master
        && aux_tx_running && link_up && aux_tx_sync_rfp |=>
        {aux_tx_pos.hfn, aux_tx_pos.bf, aux_tx_pos.seq} == 23'h0
        && aux_tx_hf_pulse) else $error("resync ignored");
    a_ctrl_lane: assert property (aux_tx_running |->
        aux_tx_pos.ctrl == ((aux_tx_pos.seq == 7'h00) ? 4'h8 : 4'h0))
        else $error("control lanes wrong");
    // =====================================================
    // Error and line side
    // =====================================================
    a_err_cause: assert property (aux_tx_err |->
        $past(aux_tx_mask[31:24]) != 8'h00) else $error("error no cause");
    a_err_single: assert property (aux_tx_err |=> !aux_tx_err)
        else $error("error longer than one cycle");
    a_word_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_word)) else $error("word dropped");
endmodule : aux_tx_write_latency_insert_properties

bind aux_tx_write_latency_insert aux_tx_write_latency_insert_properties #(
    .WORDS_PER_BF(WORDS_PER_BF), .LATENCY(LATENCY), .HFN_MAX(HFN_MAX)
) u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .radio_controller_master(radio_controller_master), .link_up(link_up),
    .rx_hf_start(rx_hf_start), .aux_tx_pos(aux_tx_pos),
    .aux_tx_bf_pulse(aux_tx_bf_pulse), .aux_tx_hf_pulse(aux_tx_hf_pulse),
    .aux_tx_running(aux_tx_running), .aux_tx_sync_rfp(aux_tx_sync_rfp),
    .aux_tx_data(aux_tx_data), .aux_tx_mask(aux_tx_mask),
    .core_word(core_word), .aux_tx_err(aux_tx_err),
    .aux_tx_stall(aux_tx_stall), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

// [verif/aux_user_model.sv]
// User logic model: answers each shown position with data and mask.
// Assumes core_clk domain; samples at rising, drives at falling edge.
`timescale 1ns/1ps
module aux_user_model #(
    parameter int LAT = 0
) (
    // Clock
    input wire logic core_clk,
    // Position from the block
    input aux_tx_pkg::pos_s aux_tx_pos,
    input wire logic aux_tx_stall,
    // Scenario control
    input wire logic bad_mask,
    // Word toward the block
    output logic [31:0] aux_tx_data,
    output logic [31:0] aux_tx_mask
);
    import aux_tx_pkg::*;
    pos_s hist[LAT+1];
    pos_s p;
    // =====================================================
    // Position history, frozen while stalled
    // =====================================================
    initial begin
        foreach (hist[i]) hist[i] = '0;
        aux_tx_data = 32'h0;
        aux_tx_mask = 32'h0;
    end
    // Shift only on edges the block also advances on
    always @(posedge core_clk) begin
        if (!aux_tx_stall) begin
            hist[0] <= aux_tx_pos;
            for (int i = 1; i <= LAT; i++) hist[i] <= hist[i-1];
        end
    end
    // Answer exactly 1+LAT cycles after the position; clear control lane
    always @(negedge core_clk) begin
        p = hist[LAT];
        aux_tx_data <= {p.hfn, p.bf, 1'b0, p.seq, 8'h5A};
        aux_tx_mask <= {(p.ctrl[3] && !bad_mask) ? 8'h00 : 8'hFF, 24'hFF0F00};
    end
endmodule : aux_user_model

// [verif/tb_top.sv]
// Testbench: streams, stalls, error and resync of the insertion block.
// Assumes four words per basic frame, zero extra latency; master mode except in test_slave.
`timescale 1ns/1ps
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    failures++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import aux_tx_pkg::*;
    localparam logic [31:0] CORE = 32'h11223344;
    logic core_clk = 0, sys_rst = 1, link_up = 0, sync_rfp = 0;
    logic tx_ready = 1, bad = 0, sb_on = 1, master = 1, rx_hf = 0;
    logic bf_p, hf_p, run, err, stall, tx_valid;
    logic [31:0] data, mask;
    pos_s pos;
    frame_word_s tx_word;
    int k = 0, errs = 0, failures = 0, num_checks = 0;
    // =====================================================
    // Clock, block and user model
    // =====================================================
    always #12.5 core_clk = ~core_clk;
    aux_tx_write_latency_insert #(.WORDS_PER_BF(4), .LATENCY(0),
        .HFN_MAX(2)) u_aux_tx_write_latency_insert (.core_clk(core_clk),
        .sys_rst(sys_rst), .radio_controller_master(master),
        .link_up(link_up), .rx_hf_start(rx_hf), .aux_tx_pos(pos),
        .aux_tx_bf_pulse(bf_p), .aux_tx_hf_pulse(hf_p),
        .aux_tx_running(run), .aux_tx_sync_rfp(sync_rfp),
        .aux_tx_data(data), .aux_tx_mask(mask), .core_word(CORE),
        .aux_tx_err(err), .aux_tx_stall(stall), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    aux_user_model #(.LAT(0)) u_aux_user_model (.core_clk(core_clk),
        .aux_tx_pos(pos), .aux_tx_stall(stall), .bad_mask(bad),
        .aux_tx_data(data), .aux_tx_mask(mask));
    // Expected n-th word after the run starts
    function automatic frame_word_s exp_word(int n);
        frame_word_s w;
        logic [31:0] m;
        logic [31:0] b;
        w.pos.hfn = 8'(n / 1024);
        w.pos.bf = 8'(n / 4);
        w.pos.seq = 7'(n % 4);
        w.pos.ctrl = (n % 4 == 0) ? 4'h8 : 4'h0;
        m = {(w.pos.ctrl[3] && !bad) ? 8'h00 : 8'hFF, 24'hFF0F00};
        b = CORE;
        if (n == 0) b[31:24] = SYNC_CHAR;
        w.data = (m & {w.pos.hfn, w.pos.bf, 1'b0, w.pos.seq, 8'h5A}) |
            (~m & b);
        return w;
    endfunction : exp_word
    // Scoreboard of accepted words and error pulses
    always @(posedge core_clk) begin
        if (!sys_rst && sb_on && tx_valid && tx_ready) begin
            `CHECK(tx_word, exp_word(k))
            k <= k + 1;
        end
        if (!sys_rst && err) errs <= errs + 1;
    end
    // =====================================================
    // Scenario tasks
    // =====================================================
    task automatic start(input logic b, input logic m);
        sys_rst = 1;
        link_up = 0;
        bad = b;
        master = m;
        sb_on = 1;
        repeat (8) @(negedge core_clk);
        sys_rst = 0;
        k = 0;
        errs = 0;
        link_up = 1;
    endtask : start
    task automatic wait_words(input int n);
        for (int i = 0; i < n + 300 && k < n; i++) @(negedge core_clk);
        `CHECK(k >= n, 1'b1)
    endtask : wait_words
    task automatic test_stream();
        start(0, 1);
        wait_words(1030);
        `CHECK(pos.hfn, 8'h01)
        `CHECK(errs, 0)
        $display("test_stream done");
    endtask : test_stream
    task automatic test_stall();
        tx_ready = 0;
        repeat (6) @(negedge core_clk);
        `CHECK(stall, 1'b1)
        tx_ready = 1;
        wait_words(k + 10);
        $display("test_stall done");
    endtask : test_stall
    task automatic test_error();
        start(1, 1);
        wait_words(9);
        `CHECK(errs, 1)
        $display("test_error done");
    endtask : test_error
    task automatic test_resync();
        sb_on = 0;
        sync_rfp = 1;
        @(negedge core_clk);
        sync_rfp = 0;
        `CHECK({pos.hfn, pos.bf, pos.seq, bf_p, hf_p}, 25'h3)
        $display("test_resync done");
    endtask : test_resync
    task automatic test_slave();
        start(0, 0);
        repeat (3) @(negedge core_clk);
        `CHECK(run, 1'b0)
        rx_hf = 1;
        @(negedge core_clk);
        rx_hf = 0;
        `CHECK({run, bf_p, hf_p}, 3'h7)
        wait_words(4);
        sync_rfp = 1;
        @(negedge core_clk);
        sync_rfp = 0;
        `CHECK(hf_p, 1'b0)
        wait_words(k + 8);
        $display("test_slave done");
    endtask : test_slave
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // =====================================================
    // Main sequence and watchdog
    // =====================================================
    initial begin
        test_stream();
        test_stall();
        test_error();
        test_resync();
        test_slave();
        end_of_test();
    end
    initial begin
        #(25 * 3000);
        failures++;
        end_of_test();
    end
endmodule : tb_top
